// *** src/tpio_top.v ***
// Overview of operation
// - Level bit 0: output starts low.
// - Level bit 1: output starts high.
// - Action 00 disables pin; 01 drives low.
// - Action 10 drives pin high on match.
// - Action 11 toggles pin on match.
// - Top bit 1 captures; 00 rising edge.
// - Capture action 01 uses falling edge.
// - Capture action 1x uses both edges.
// - Channel 5 capture ignores level bit.
// - Channel 0 level 0 captures own pin.
// - Channel 0 pattern 11xx uses channel 1.
// - Then capture on each channel 1 count.
//
// Top of the timer pin I/O mode block: register port, control fields,
// and the two general register channels.
// Assumes counters and the channel 1 count event come from the timer core.
`timescale 1ns/1ps
`include "tpio_map.vh"

module tpio_top #(
  parameter CNT_W = 16
) (
  input wire I_REF_CLK,
  input wire I_RESET,
  input wire [7:0] I_ADDR,
  input wire [15:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output reg [15:0] O_RDATA,
  input wire [CNT_W-1:0] I_CH5_COUNTER,
  input wire [CNT_W-1:0] I_CH0_COUNTER,
  input wire I_CH1_COUNTER_EVT,
  input wire I_CH5_B_CAPTURE_COMPARE_PIN_I,
  output wire O_CH5_B_CAPTURE_COMPARE_PIN_O,
  output wire O_CH5_B_CAPTURE_COMPARE_PIN_OE,
  input wire I_CH0_A_CAPTURE_COMPARE_PIN_I,
  output wire O_CH0_A_CAPTURE_COMPARE_PIN_O,
  output wire O_CH0_A_CAPTURE_COMPARE_PIN_OE,
  output wire O_CH5_GENERAL_REG_B_EVENT,
  output wire O_CH0_GENERAL_REG_A_EVENT
);

  reg [7:0] timer_ch5_io_control_q;
  reg [7:0] timer_ch0_io_control_high_q;
  reg [`TPIO_ST_W-1:0] status_q;
  reg [`TPIO_ST_W-1:0] status_d;
  reg ch5_field_wr_q;
  reg ch0_field_wr_q;
  reg ch5_event_q;
  reg ch0_event_q;
  reg [15:0] rdata_d;

  wire [3:0] ch5_field;
  wire [3:0] ch0_field;
  wire wr_ch5_io;
  wire wr_ch0_io;
  wire wr_ch5_gr;
  wire wr_ch0_gr;
  wire wr_status;

  wire ch5_capture;
  wire ch5_drive;
  wire ch5_init_level;
  wire [1:0] ch5_action;
  wire ch5_cap_rise;
  wire ch5_cap_fall;
  wire ch5_cap_alt;
  wire ch0_capture;
  wire ch0_drive;
  wire ch0_init_level;
  wire [1:0] ch0_action;
  wire ch0_cap_rise;
  wire ch0_cap_fall;
  wire ch0_cap_alt;

  wire [CNT_W-1:0] ch5_general_reg_b;
  wire [CNT_W-1:0] ch0_general_reg_a;
  wire ch5_match;
  wire ch5_capt;
  wire ch0_match;
  wire ch0_capt;
  wire ch5_pin_q;
  wire ch5_pin_oe_q;
  wire ch0_pin_q;
  wire ch0_pin_oe_q;

  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  assign wr_ch5_io = I_WR && hit(I_ADDR, `TPIO_OFS_CH5_IO);
  assign wr_ch0_io = I_WR && hit(I_ADDR, `TPIO_OFS_CH0_IOH);
  assign wr_ch5_gr = I_WR && hit(I_ADDR, `TPIO_OFS_CH5_GRB);
  assign wr_ch0_gr = I_WR && hit(I_ADDR, `TPIO_OFS_CH0_GRA);
  assign wr_status = I_WR && hit(I_ADDR, `TPIO_OFS_STATUS);

  assign ch5_field = timer_ch5_io_control_q[`TPIO_CH5_FIELD_LSB+3:`TPIO_CH5_FIELD_LSB];
  assign ch0_field = timer_ch0_io_control_high_q[`TPIO_CH0_FIELD_LSB+3:`TPIO_CH0_FIELD_LSB];

  // The whole control byte is stored; only the field above steers the channel.
  always @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      timer_ch5_io_control_q <= `TPIO_CTL_RESET;
      timer_ch0_io_control_high_q <= `TPIO_CTL_RESET;
      ch5_field_wr_q <= 1'b0;
      ch0_field_wr_q <= 1'b0;
    end else begin
      ch5_field_wr_q <= wr_ch5_io;
      ch0_field_wr_q <= wr_ch0_io;
      if (wr_ch5_io) begin
        timer_ch5_io_control_q <= I_WDATA[7:0];
      end
      if (wr_ch0_io) begin
        timer_ch0_io_control_high_q <= I_WDATA[7:0];
      end
    end
  end

  tpio_decode #(
    .ALT_SRC(0)
  ) u_dec_ch5 (
    .i_field(ch5_field),
    .o_capture(ch5_capture),
    .o_drive(ch5_drive),
    .o_init_level(ch5_init_level),
    .o_action(ch5_action),
    .o_cap_rise(ch5_cap_rise),
    .o_cap_fall(ch5_cap_fall),
    .o_cap_alt(ch5_cap_alt)
  );

  tpio_decode #(
    .ALT_SRC(1)
  ) u_dec_ch0 (
    .i_field(ch0_field),
    .o_capture(ch0_capture),
    .o_drive(ch0_drive),
    .o_init_level(ch0_init_level),
    .o_action(ch0_action),
    .o_cap_rise(ch0_cap_rise),
    .o_cap_fall(ch0_cap_fall),
    .o_cap_alt(ch0_cap_alt)
  );

  // The field write is delayed one cycle so the decoder already sees the
  // new field when the starting level is loaded.
  tpio_chan #(
    .CNT_W(CNT_W)
  ) u_ch5_b (
    .i_clk(I_REF_CLK),
    .i_rst(I_RESET),
    .i_field_wr(ch5_field_wr_q),
    .i_capture(ch5_capture),
    .i_drive(ch5_drive),
    .i_init_level(ch5_init_level),
    .i_action(ch5_action),
    .i_cap_rise(ch5_cap_rise),
    .i_cap_fall(ch5_cap_fall),
    .i_cap_alt(ch5_cap_alt),
    .i_alt_evt(1'b0),
    .i_count(I_CH5_COUNTER),
    .i_pin(I_CH5_B_CAPTURE_COMPARE_PIN_I),
    .i_gr_wr(wr_ch5_gr),
    .i_gr_wdata(I_WDATA[CNT_W-1:0]),
    .o_gr_q(ch5_general_reg_b),
    .o_pin_q(ch5_pin_q),
    .o_pin_oe_q(ch5_pin_oe_q),
    .o_match_q(ch5_match),
    .o_capt_q(ch5_capt)
  );

  tpio_chan #(
    .CNT_W(CNT_W)
  ) u_ch0_a (
    .i_clk(I_REF_CLK),
    .i_rst(I_RESET),
    .i_field_wr(ch0_field_wr_q),
    .i_capture(ch0_capture),
    .i_drive(ch0_drive),
    .i_init_level(ch0_init_level),
    .i_action(ch0_action),
    .i_cap_rise(ch0_cap_rise),
    .i_cap_fall(ch0_cap_fall),
    .i_cap_alt(ch0_cap_alt),
    .i_alt_evt(I_CH1_COUNTER_EVT),
    .i_count(I_CH0_COUNTER),
    .i_pin(I_CH0_A_CAPTURE_COMPARE_PIN_I),
    .i_gr_wr(wr_ch0_gr),
    .i_gr_wdata(I_WDATA[CNT_W-1:0]),
    .o_gr_q(ch0_general_reg_a),
    .o_pin_q(ch0_pin_q),
    .o_pin_oe_q(ch0_pin_oe_q),
    .o_match_q(ch0_match),
    .o_capt_q(ch0_capt)
  );

  assign O_CH5_B_CAPTURE_COMPARE_PIN_O = ch5_pin_q;
  assign O_CH5_B_CAPTURE_COMPARE_PIN_OE = ch5_pin_oe_q;
  assign O_CH0_A_CAPTURE_COMPARE_PIN_O = ch0_pin_q;
  assign O_CH0_A_CAPTURE_COMPARE_PIN_OE = ch0_pin_oe_q;
  assign O_CH5_GENERAL_REG_B_EVENT = ch5_event_q;
  assign O_CH0_GENERAL_REG_A_EVENT = ch0_event_q;

  // Sticky event flags, cleared by writing one; a new event in the clearing
  // cycle survives the clear.
  always @* begin
    status_d = status_q;
    if (wr_status) begin
      status_d = status_q & ~I_WDATA[`TPIO_ST_W-1:0];
    end
    if (ch5_match) begin
      status_d[`TPIO_ST_CH5_MATCH] = 1'b1;
    end
    if (ch5_capt) begin
      status_d[`TPIO_ST_CH5_CAPT] = 1'b1;
    end
    if (ch0_match) begin
      status_d[`TPIO_ST_CH0_MATCH] = 1'b1;
    end
    if (ch0_capt) begin
      status_d[`TPIO_ST_CH0_CAPT] = 1'b1;
    end
  end

  always @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      status_q <= `TPIO_STATUS_RESET;
      ch5_event_q <= 1'b0;
      ch0_event_q <= 1'b0;
    end else begin
      status_q <= status_d;
      ch5_event_q <= ch5_match || ch5_capt;
      ch0_event_q <= ch0_match || ch0_capt;
    end
  end

  // Read mux; unmapped offsets read as zero.
  always @* begin
    rdata_d = 16'h0000;
    case (I_ADDR)
      `TPIO_OFS_CH5_IO: rdata_d = {8'h00, timer_ch5_io_control_q};
      `TPIO_OFS_CH0_IOH: rdata_d = {8'h00, timer_ch0_io_control_high_q};
      `TPIO_OFS_CH5_GRB: rdata_d = ch5_general_reg_b;
      `TPIO_OFS_CH0_GRA: rdata_d = ch0_general_reg_a;
      `TPIO_OFS_STATUS: rdata_d = {12'h000, status_q};
      `TPIO_OFS_PINS: rdata_d = {8'h00, I_CH0_A_CAPTURE_COMPARE_PIN_I, ch0_pin_oe_q,
        ch0_pin_q, 1'b0, I_CH5_B_CAPTURE_COMPARE_PIN_I, ch5_pin_oe_q, ch5_pin_q, 1'b0};
      `TPIO_OFS_MODES: rdata_d = {8'h00, ch0_cap_alt, ch0_cap_fall, ch0_cap_rise,
        ch0_capture, ch5_cap_alt, ch5_cap_fall, ch5_cap_rise, ch5_capture};
      default: rdata_d = 16'h0000;
    endcase
  end

  // Read data stand only in the cycle after the strobe, zero otherwise.
  always @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      O_RDATA <= 16'h0000;
    end else if (I_RD) begin
      O_RDATA <= rdata_d;
    end else begin
      O_RDATA <= 16'h0000;
    end
  end

endmodule // tpio_top

// *** src/tpio_map.vh ***
// Address map, field positions, reset values and action codes of the
// timer pin I/O mode block.
// Assumes it is included by bare name from every design file that needs it.
`ifndef TPIO_MAP_VH
`define TPIO_MAP_VH

`define TPIO_ADDR_W 8
`define TPIO_DATA_W 16
`define TPIO_CTL_W 8
`define TPIO_FIELD_W 4

`define TPIO_OFS_CH5_IO 8'h00
`define TPIO_OFS_CH0_IOH 8'h04
`define TPIO_OFS_CH5_GRB 8'h08
`define TPIO_OFS_CH0_GRA 8'h0c
`define TPIO_OFS_STATUS 8'h10
`define TPIO_OFS_PINS 8'h14
`define TPIO_OFS_MODES 8'h18

`define TPIO_CH5_FIELD_LSB 4
`define TPIO_CH0_FIELD_LSB 0

`define TPIO_FLD_FUNC 3
`define TPIO_FLD_LEVEL 2
`define TPIO_FLD_ACT_HI 1
`define TPIO_FLD_ACT_LO 0

`define TPIO_ACT_OFF 2'h0
`define TPIO_ACT_LOW 2'h1
`define TPIO_ACT_HIGH 2'h2
`define TPIO_ACT_TOGGLE 2'h3

`define TPIO_CTL_RESET 8'h00
`define TPIO_GR_RESET 16'hffff
`define TPIO_STATUS_RESET 4'h0

`define TPIO_ST_CH5_MATCH 0
`define TPIO_ST_CH5_CAPT 1
`define TPIO_ST_CH0_MATCH 2
`define TPIO_ST_CH0_CAPT 3
`define TPIO_ST_W 4

`endif

// *** src/tpio_decode.v ***
// Combinational decoder of one four-bit pin I/O control field.
// Assumes the field comes straight from a control register flip-flop.
`timescale 1ns/1ps
`include "tpio_map.vh"

module tpio_decode #(
  parameter ALT_SRC = 0
) (
  input wire [3:0] i_field,
  output reg o_capture,
  output reg o_drive,
  output reg o_init_level,
  output reg [1:0] o_action,
  output reg o_cap_rise,
  output reg o_cap_fall,
  output reg o_cap_alt
);

  always @* begin
    o_capture = i_field[`TPIO_FLD_FUNC];
    o_action = i_field[`TPIO_FLD_ACT_HI:`TPIO_FLD_ACT_LO];
    o_init_level = i_field[`TPIO_FLD_LEVEL];
    o_drive = 1'b0;
    o_cap_rise = 1'b0;
    o_cap_fall = 1'b0;
    o_cap_alt = 1'b0;
    if (!o_capture) begin
      o_drive = (o_action != `TPIO_ACT_OFF);
    end else if ((ALT_SRC != 0) && i_field[`TPIO_FLD_LEVEL]) begin
      o_cap_alt = 1'b1;
    end else begin
      // Channel 5 never looks at the level bit here, so it falls through.
      o_cap_rise = (o_action == 2'h0) || o_action[1];
      o_cap_fall = (o_action == 2'h1) || o_action[1];
    end
  end

endmodule // tpio_decode

// *** src/tpio_chan.v ***
// One general register with its compare output pin and capture input.
// Assumes the counter value and pin input are synchronous to the clock.
`timescale 1ns/1ps
`include "tpio_map.vh"

module tpio_chan #(
  parameter CNT_W = 16
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_field_wr,
  input wire i_capture,
  input wire i_drive,
  input wire i_init_level,
  input wire [1:0] i_action,
  input wire i_cap_rise,
  input wire i_cap_fall,
  input wire i_cap_alt,
  input wire i_alt_evt,
  input wire [CNT_W-1:0] i_count,
  input wire i_pin,
  input wire i_gr_wr,
  input wire [CNT_W-1:0] i_gr_wdata,
  output reg [CNT_W-1:0] o_gr_q,
  output reg o_pin_q,
  output reg o_pin_oe_q,
  output reg o_match_q,
  output reg o_capt_q
);

  reg pin_prev_q;
  wire match;
  wire capt;

  assign match = !i_capture && (i_count == o_gr_q);
  assign capt = i_capture && (i_cap_alt ? i_alt_evt :
    ((i_cap_rise && i_pin && !pin_prev_q) || (i_cap_fall && !i_pin && pin_prev_q)));

  always @(posedge i_clk) begin
    if (i_rst) begin
      o_gr_q <= `TPIO_GR_RESET;
      o_pin_q <= 1'b0;
      o_pin_oe_q <= 1'b0;
      o_match_q <= 1'b0;
      o_capt_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= i_pin;
      o_match_q <= match;
      o_capt_q <= capt;
      o_pin_oe_q <= i_drive;
      // A capture beats a software write of the same cycle.
      if (capt) begin
        o_gr_q <= i_count;
      end else if (i_gr_wr) begin
        o_gr_q <= i_gr_wdata;
      end
      if (i_field_wr && i_drive) begin
        o_pin_q <= i_init_level;
      end else if (match && i_drive) begin
        case (i_action)
          `TPIO_ACT_LOW: o_pin_q <= 1'b0;
          `TPIO_ACT_HIGH: o_pin_q <= 1'b1;
          `TPIO_ACT_TOGGLE: o_pin_q <= !o_pin_q;
          default: o_pin_q <= o_pin_q;
        endcase
      end
    end
  end

endmodule // tpio_chan

// *** testbench/tpio_props.sv ***
// Concurrent checks of the timer pin I/O mode block at its top ports.
// Assumes the control and general register offsets of the block's map.
`timescale 1ns/1ps
module tpio_props #(
  parameter CNT_W = 16
) (
  input wire I_REF_CLK,
  input wire I_RESET,
  input wire [7:0] I_ADDR,
  input wire [15:0] I_WDATA,
  input wire I_WR,
  input wire [CNT_W-1:0] I_CH5_COUNTER,
  input wire [CNT_W-1:0] I_CH0_COUNTER,
  input wire I_CH1_COUNTER_EVT,
  input wire I_CH5_B_CAPTURE_COMPARE_PIN_I,
  input wire O_CH5_B_CAPTURE_COMPARE_PIN_O,
  input wire O_CH5_B_CAPTURE_COMPARE_PIN_OE,
  input wire I_CH0_A_CAPTURE_COMPARE_PIN_I,
  input wire O_CH0_A_CAPTURE_COMPARE_PIN_OE,
  input wire O_CH5_GENERAL_REG_B_EVENT,
  input wire O_CH0_GENERAL_REG_A_EVENT
);
  reg [7:0] c5_q;
  reg [7:0] c0_q;
  reg [CNT_W-1:0] g5_q;
  reg [CNT_W-1:0] g0_q;
  reg w5_q;
  reg w0_q;
  wire w5 = I_WR && I_ADDR == 8'h00;
  wire w0 = I_WR && I_ADDR == 8'h04;
  wire [3:0] f5 = c5_q[7:4];
  wire [3:0] f0 = c0_q[3:0];
  // A field write takes two cycles to reach the pins, so those cycles are skipped.
  wire s5 = !w5 && !w5_q;
  wire s0 = !w0 && !w0_q;
  wire m5 = !f5[3] && I_CH5_COUNTER == g5_q;
  wire m0 = !f0[3] && I_CH0_COUNTER == g0_q;
  always @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      c5_q <= 8'h00;
      c0_q <= 8'h00;
      g5_q <= {CNT_W{1'b1}};
      g0_q <= {CNT_W{1'b1}};
      w5_q <= 1'b0;
      w0_q <= 1'b0;
    end else begin
      w5_q <= w5;
      w0_q <= w0;
      if (w5) c5_q <= I_WDATA[7:0];
      if (w0) c0_q <= I_WDATA[7:0];
      if (I_WR && I_ADDR == 8'h08) g5_q <= I_WDATA[CNT_W-1:0];
      if (I_WR && I_ADDR == 8'h0c) g0_q <= I_WDATA[CNT_W-1:0];
    end
  end
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET);
  a_oe5_follow: assert property (
    s5 |-> O_CH5_B_CAPTURE_COMPARE_PIN_OE == (!f5[3] && f5[1:0] != 2'h0))
    else $error("ch5 output enable wrong");
  a_oe0_follow: assert property (
    s0 |-> O_CH0_A_CAPTURE_COMPARE_PIN_OE == (!f0[3] && f0[1:0] != 2'h0))
    else $error("ch0 output enable wrong");
  a_start_level: assert property (
    w5_q && !f5[3] && f5[1:0] != 2'h0 |=> O_CH5_B_CAPTURE_COMPARE_PIN_O == f5[2])
    else $error("ch5 starting level wrong");
  a_match_action: assert property (
    s5 && m5 && f5[1:0] != 2'h0 |=> O_CH5_B_CAPTURE_COMPARE_PIN_O == (f5[1:0] == 2'h1 ?
    1'b0 : f5[1:0] == 2'h2 ? 1'b1 : !$past(O_CH5_B_CAPTURE_COMPARE_PIN_O)))
    else $error("ch5 pin action at match wrong");
  // The match is registered in the channel and again for the event pin, so two edges.
  a_match5_evt: assert property (m5 |-> ##2 O_CH5_GENERAL_REG_B_EVENT)
    else $error("ch5 match event missing");
  a_match0_evt: assert property (m0 |-> ##2 O_CH0_GENERAL_REG_A_EVENT)
    else $error("ch0 match event missing");
  a_cap5_edge: assert property (
    s5 && f5[3] && ($rose(I_CH5_B_CAPTURE_COMPARE_PIN_I) && f5[1:0] != 2'h1 ||
    $fell(I_CH5_B_CAPTURE_COMPARE_PIN_I) && f5[1:0] != 2'h0) |-> ##[1:3] O_CH5_GENERAL_REG_B_EVENT)
    else $error("ch5 capture missing");
  a_cap0_edge: assert property (
    s0 && f0[3:2] == 2'h2 && ($rose(I_CH0_A_CAPTURE_COMPARE_PIN_I) && f0[1:0] != 2'h1 ||
    $fell(I_CH0_A_CAPTURE_COMPARE_PIN_I) && f0[1:0] != 2'h0) |-> ##[1:3] O_CH0_GENERAL_REG_A_EVENT)
    else $error("ch0 capture missing");
  a_alt_source: assert property (
    s0 && f0[3:2] == 2'h3 && I_CH1_COUNTER_EVT |-> ##[1:3] O_CH0_GENERAL_REG_A_EVENT)
    else $error("ch0 count capture missing");
  c_toggle5: cover property (m5 && f5[1:0] == 2'h3);
  c_cap5: cover property (f5[3] && O_CH5_GENERAL_REG_B_EVENT);
  c_alt0: cover property (f0[3:2] == 2'h3 && O_CH0_GENERAL_REG_A_EVENT);
endmodule // tpio_props

bind tpio_top tpio_props #(.CNT_W(CNT_W)) u_props (.I_REF_CLK, .I_RESET, .I_ADDR, .I_WDATA,
  .I_WR, .I_CH5_COUNTER, .I_CH0_COUNTER, .I_CH1_COUNTER_EVT, .I_CH5_B_CAPTURE_COMPARE_PIN_I,
  .O_CH5_B_CAPTURE_COMPARE_PIN_O, .O_CH5_B_CAPTURE_COMPARE_PIN_OE,
  .I_CH0_A_CAPTURE_COMPARE_PIN_I, .O_CH0_A_CAPTURE_COMPARE_PIN_OE,
  .O_CH5_GENERAL_REG_B_EVENT, .O_CH0_GENERAL_REG_A_EVENT);

// *** testbench/tpio_pin_model.sv ***
// Model of the far side of one capture/compare pin.
// Assumes the outside world drives its own level whenever the block releases the pin.
`timescale 1ns/1ps
module tpio_pin_model (
  input wire i_oe,
  input wire i_o,
  input wire i_ext,
  output wire o_level
);
  assign o_level = i_oe ? i_o : i_ext;
endmodule // tpio_pin_model

// *** testbench/tpio_tb.sv ***
// Self-checking bench of the timer pin I/O mode block with pin models.
// Assumes the register map of the block and one-cycle read latency.
`timescale 1ns/1ps
module tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] addr = 8'h00;
  reg [15:0] wdata = 16'h0000;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [15:0] cnt5 = 16'h0000;
  reg [15:0] cnt0 = 16'h0000;
  reg ch1_evt = 1'b0;
  reg ext5 = 1'b0;
  reg ext0 = 1'b0;
  reg [15:0] v;
  reg [15:0] got;
  wire [15:0] rdata;
  wire pi5, po5, oe5, pi0, po0, oe0, ev5, ev0;
  integer n_mismatch = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  integer evn5 = 0;
  integer evn0 = 0;
  integer f, c, k, base, seed;
  always #2 clk = ~clk;
  tpio_top #(.CNT_W(16)) u_dut (.I_REF_CLK(clk), .I_RESET(rst), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_CH5_COUNTER(cnt5),
    .I_CH0_COUNTER(cnt0), .I_CH1_COUNTER_EVT(ch1_evt), .I_CH5_B_CAPTURE_COMPARE_PIN_I(pi5),
    .O_CH5_B_CAPTURE_COMPARE_PIN_O(po5), .O_CH5_B_CAPTURE_COMPARE_PIN_OE(oe5),
    .I_CH0_A_CAPTURE_COMPARE_PIN_I(pi0), .O_CH0_A_CAPTURE_COMPARE_PIN_O(po0),
    .O_CH0_A_CAPTURE_COMPARE_PIN_OE(oe0), .O_CH5_GENERAL_REG_B_EVENT(ev5),
    .O_CH0_GENERAL_REG_A_EVENT(ev0));
  tpio_pin_model u_pin5 (.i_oe(oe5), .i_o(po5), .i_ext(ext5), .o_level(pi5));
  tpio_pin_model u_pin0 (.i_oe(oe0), .i_o(po0), .i_ext(ext0), .o_level(pi0));
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    evn5 <= evn5 + ev5;
    evn0 <= evn0 + ev0;
    if (cyc == 5000) begin
      n_mismatch = n_mismatch + 1;
      test_done;
    end
  end
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wreg(input [7:0] a, input [15:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rreg(input [7:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 got = rdata;
    end
  endtask
  // Output compare: write the mode, check the starting level, then one match.
  task oc_run;
    begin
      v = $urandom_range(16'hfffe, 1);
      wreg(c ? 8'h0c : 8'h08, v);
      wreg(c ? 8'h04 : 8'h00, c ? f : f << 4);
      rreg(c ? 8'h04 : 8'h00);
      chk("control", c ? f : f << 4, got);
      #1 chk("oe", f[1:0] != 0, c ? oe0 : oe5);
      if (f[1:0] != 0) chk("start", f[2], c ? po0 : po5);
      base = c ? evn0 : evn5;
      @(posedge clk);
      if (c) cnt0 <= v;
      else cnt5 <= v;
      @(posedge clk);
      cnt0 <= 16'h0000;
      cnt5 <= 16'h0000;
      repeat (3) @(posedge clk);
      #1 chk("events", 1, (c ? evn0 : evn5) - base);
      if (f[1:0] != 0) chk("pin", f[1:0] == 3 ? !f[2] : f[1], c ? po0 : po5);
      rreg(8'h10);
      chk("status", c ? 4 : 1, got);
      wreg(8'h10, 16'h000f);
    end
  endtask
  // Capture: two pin toggles and two channel 1 counts, only the chosen source counts.
  task cap_run;
    begin
      v = $urandom_range(16'hfffe, 1);
      @(posedge clk);
      cnt5 <= v;
      cnt0 <= v;
      wreg(c ? 8'h04 : 8'h00, c ? f : f << 4);
      repeat (3) @(posedge clk);
      #1 base = c ? evn0 : evn5;
      for (k = 0; k < 2; k = k + 1) begin
        @(posedge clk);
        if (c) ext0 <= !ext0;
        else ext5 <= !ext5;
        ch1_evt <= 1'b1;
        @(posedge clk);
        ch1_evt <= 1'b0;
        repeat (4) @(posedge clk);
      end
      #1 chk("captures", f[1] || c && f[2] ? 2 : 1, (c ? evn0 : evn5) - base);
      k = (c && f[2]) ? 9 : 4 * (f[1:0] != 0) + 2 * (f[1:0] != 1) + 1;
      rreg(8'h18);
      chk("modes", c ? k << 4 | 7 : k, got);
      rreg(c ? 8'h0c : 8'h08);
      chk("captured", v, got);
      rreg(8'h10);
      chk("status", c ? 8 : 2, got);
      wreg(8'h10, 16'h000f);
    end
  endtask
  initial begin
    seed = $urandom(93);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wreg(8'h1c, 16'hffff);
    for (k = 0; k < 6; k = k + 1) begin
      rreg(k == 5 ? 8'h1c : k * 4);
      chk("reset value", k == 2 || k == 3 ? 16'hffff : 16'h0000, got);
    end
    for (c = 0; c < 2; c = c + 1) begin
      for (f = 0; f < 8; f = f + 1) oc_run;
    end
    for (c = 0; c < 2; c = c + 1) begin
      for (f = 8; f < 16; f = f + 1) cap_run;
    end
    test_done;
  end
endmodule // tb
